//--- pkg/comparator_pkg.sv
// Constants shared by the comparator control and event logic
package comparator_pkg;
   localparam int          ADDR_WIDTH      = 4;
   localparam logic [3:0]  CONTROL_OFFSET  = 4'h0;
   localparam logic [3:0]  STATUS_OFFSET   = 4'h4;
   localparam logic [3:0]  MASK_OFFSET     = 4'h8;
   localparam int          ENABLE_BIT      = 15;
   localparam int          DRIVE_BIT       = 14;
   localparam int          INVERT_BIT      = 13;
   localparam int          RESULT_BIT      = 8;
   localparam int          EDGE_LSB        = 6;
   localparam int          POSITIVE_BIT    = 4;
   localparam int          NEGATIVE_LSB    = 0;
   localparam int          EVENT_BIT       = 0;
   localparam logic [31:0] CONTROL_RESET   = 32'h000000C3;
   localparam logic [31:0] CONTROL_MASK    = 32'h0000E1D3;
   localparam logic [1:0]  EDGE_NONE       = 2'h0;
   localparam logic [1:0]  EDGE_RISING     = 2'h1;
   localparam logic [1:0]  EDGE_FALLING    = 2'h2;
   localparam logic [1:0]  EDGE_BOTH       = 2'h3;
   localparam logic [1:0]  NEGATIVE_PIN_B  = 2'h0;
   localparam logic [1:0]  NEGATIVE_PIN_C  = 2'h1;
   localparam logic [1:0]  NEGATIVE_PIN_D  = 2'h2;
   localparam logic [1:0]  NEGATIVE_REF    = 2'h3;
   localparam logic        STATUS_RESET    = 1'h0;
   localparam logic        MASK_RESET      = 1'h0;
   localparam int          SYNC_CYCLES     = 2;
endpackage

//--- pkg/result_edge_if.sv
// Signals between the control logic and the result edge detector
`timescale 1ns/10ps
interface result_edge_if;
   logic enable;
   logic invert;
   logic result;
   logic rise;
   logic fall;
   modport detector (input enable, input invert, output result, output rise, output fall);
   modport control  (output enable, output invert, input result, input rise, input fall);
endinterface

//--- verilog/result_edge_detector.sv
// Synchroniser, inversion and edge detection of the comparator result
`timescale 1ns/10ps
module result_edge_detector (
   input  wire logic      clock,
   input  wire logic      srst,
   input  wire logic      comparator_result,
   result_edge_if.detector edges
);
   // ----------------------------------------
   // Synchroniser
   // ----------------------------------------
   logic sync_first;
   logic sync_second;
   logic previous;
   logic armed;

   always_ff @(posedge clock) begin
      if (srst) begin
         sync_first  <= 1'h0;
         sync_second <= 1'h0;
      end else begin
         sync_first  <= comparator_result;
         sync_second <= sync_first;
      end
   end

   // ----------------------------------------
   // Inversion and edges
   // ----------------------------------------
   assign edges.result = sync_second ^ edges.invert;

   // Edge sees the inverted result, so inversion flips the edge
   always_ff @(posedge clock) begin
      if (srst) begin
         previous <= 1'h0;
         armed    <= 1'h0;
      end else begin
         previous <= edges.result;
         armed    <= edges.enable;
      end
   end

   // Arming skips a false edge on the switch-on cycle itself, the first with enable set
   assign edges.rise = armed & edges.enable & edges.result & ~previous;
   assign edges.fall = armed & edges.enable & ~edges.result & previous;

   a_edge_needs_enable: assert property (@(posedge clock) disable iff (srst)
      (edges.rise | edges.fall) |-> edges.enable && $past(edges.enable))
      else $error("Edge reported while comparator is off");
   a_rise_after_low: assert property (@(posedge clock) disable iff (srst)
      edges.rise |-> edges.result && !$past(edges.result))
      else $error("Rise without a low to high result");
endmodule

//--- verilog/comparator_control_event.sv
// Comparator control register, result status and edge interrupt logic
`timescale 1ns/10ps
module comparator_control_event (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   input  wire logic        comparator_result,
   output logic             comparator_enable,
   output logic             positive_input_select,
   output logic      [1:0]  negative_input_select,
   output logic             result_output_pin,
   output logic             result_output_pin_oe,
   output logic             event_pulse,
   output logic             interrupt
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   result_edge_if edges ();

   logic        enable;
   logic        drive;
   logic        invert;
   logic [1:0]  edge_select;
   logic        positive_select;
   logic [1:0]  negative_select;
   logic        event_status;
   logic        event_mask;
   logic        read_done;
   logic        next_event;
   logic        write_control;
   logic        write_status;
   logic        write_mask;
   logic [31:0] control_word;
   logic [31:0] next_readdata;

   // ----------------------------------------
   // Edge detector
   // ----------------------------------------
   result_edge_detector u_result_edge_detector (
      .clock             (clock),
      .srst              (srst),
      .comparator_result (comparator_result),
      .edges             (edges)
   );

   assign edges.enable = enable;
   assign edges.invert = invert;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   // Writes finish at once; reads take one wait cycle for registered data
   assign waitrequest   = read & ~read_done;
   assign write_control = write & (address == comparator_pkg::CONTROL_OFFSET);
   assign write_status  = write & (address == comparator_pkg::STATUS_OFFSET);
   assign write_mask    = write & (address == comparator_pkg::MASK_OFFSET);

   always_ff @(posedge clock) begin
      if (srst) begin
         read_done <= 1'h0;
      end else begin
         read_done <= read & ~read_done;
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         enable          <= comparator_pkg::CONTROL_RESET[comparator_pkg::ENABLE_BIT];
         drive           <= comparator_pkg::CONTROL_RESET[comparator_pkg::DRIVE_BIT];
         invert          <= comparator_pkg::CONTROL_RESET[comparator_pkg::INVERT_BIT];
         edge_select     <= comparator_pkg::CONTROL_RESET[comparator_pkg::EDGE_LSB +: 2];
         positive_select <= comparator_pkg::CONTROL_RESET[comparator_pkg::POSITIVE_BIT];
         negative_select <= comparator_pkg::CONTROL_RESET[comparator_pkg::NEGATIVE_LSB +: 2];
      end else if (write_control) begin
         if (byteenable[1]) begin
            enable <= writedata[comparator_pkg::ENABLE_BIT];
            drive  <= writedata[comparator_pkg::DRIVE_BIT];
            invert <= writedata[comparator_pkg::INVERT_BIT];
         end
         if (byteenable[0]) begin
            edge_select     <= writedata[comparator_pkg::EDGE_LSB +: 2];
            positive_select <= writedata[comparator_pkg::POSITIVE_BIT];
            negative_select <= writedata[comparator_pkg::NEGATIVE_LSB +: 2];
         end
      end
   end

   // ----------------------------------------
   // Analog and pin controls
   // ----------------------------------------
   assign comparator_enable     = enable;
   assign positive_input_select = positive_select;
   assign negative_input_select = negative_select;

   // Pin stays low and undriven when the drive bit is clear
   always_ff @(posedge clock) begin
      if (srst) begin
         result_output_pin    <= 1'h0;
         result_output_pin_oe <= 1'h0;
      end else begin
         result_output_pin    <= drive & edges.result;
         result_output_pin_oe <= drive;
      end
   end

   // ----------------------------------------
   // Event selection
   // ----------------------------------------
   always_comb begin
      case (edge_select)
         comparator_pkg::EDGE_NONE:    next_event = 1'h0;
         comparator_pkg::EDGE_RISING:  next_event = edges.rise;
         comparator_pkg::EDGE_FALLING: next_event = edges.fall;
         comparator_pkg::EDGE_BOTH:    next_event = edges.rise | edges.fall;
         default:                      next_event = 1'h0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         event_pulse <= 1'h0;
      end else begin
         event_pulse <= next_event;
      end
   end

   // ----------------------------------------
   // Interrupt status and mask
   // ----------------------------------------
   // A new event beats a write-one clear in the same cycle
   always_ff @(posedge clock) begin
      if (srst) begin
         event_status <= comparator_pkg::STATUS_RESET;
      end else if (next_event) begin
         event_status <= 1'h1;
      end else if (write_status && byteenable[0] && writedata[comparator_pkg::EVENT_BIT]) begin
         event_status <= 1'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         event_mask <= comparator_pkg::MASK_RESET;
      end else if (write_mask && byteenable[0]) begin
         event_mask <= writedata[comparator_pkg::EVENT_BIT];
      end
   end

   assign interrupt = event_status & event_mask;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      control_word = 32'h00000000;
      control_word[comparator_pkg::ENABLE_BIT]         = enable;
      control_word[comparator_pkg::DRIVE_BIT]          = drive;
      control_word[comparator_pkg::INVERT_BIT]         = invert;
      control_word[comparator_pkg::RESULT_BIT]         = edges.result;
      control_word[comparator_pkg::EDGE_LSB +: 2]      = edge_select;
      control_word[comparator_pkg::POSITIVE_BIT]       = positive_select;
      control_word[comparator_pkg::NEGATIVE_LSB +: 2]  = negative_select;
   end

   always_comb begin
      next_readdata = 32'h00000000;
      case (address)
         comparator_pkg::CONTROL_OFFSET: next_readdata = control_word;
         comparator_pkg::STATUS_OFFSET:  next_readdata[comparator_pkg::EVENT_BIT] = event_status;
         comparator_pkg::MASK_OFFSET:    next_readdata[comparator_pkg::EVENT_BIT] = event_mask;
         default:                        next_readdata = 32'h00000000;
      endcase
   end

   // Data captured in the wait cycle and held until the next read
   always_ff @(posedge clock) begin
      if (srst) begin
         readdata <= 32'h00000000;
      end else if (read && !read_done) begin
         readdata <= next_readdata;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_enable_write_only: assert property (@(posedge clock) disable iff (srst)
      write_control && !byteenable[1] |=> enable == $past(enable)
         && invert == $past(invert))
      else $error("Control upper byte changed without its byte enable");
   a_enable_takes_bit: assert property (@(posedge clock) disable iff (srst)
      write_control && byteenable[1] |=>
         comparator_enable == $past(writedata[15])
         && edge_select == ($past(byteenable[0]) ? $past(writedata[7:6]) : $past(edge_select)))
      else $error("Enable write wrong or disturbed other fields");
   a_drive_takes_bit: assert property (@(posedge clock) disable iff (srst)
      write_control && byteenable[1] |=>
         drive == $past(writedata[comparator_pkg::DRIVE_BIT])
         && invert == $past(writedata[comparator_pkg::INVERT_BIT]))
      else $error("Drive or invert bit did not take written value");
   a_pin_follows_drive: assert property (@(posedge clock) disable iff (srst)
      ##1 result_output_pin_oe == $past(drive)
         && result_output_pin == ($past(drive) & $past(edges.result)))
      else $error("Output pin does not follow drive and result");
   a_drive_pin_result: assert property (@(posedge clock) disable iff (srst)
      result_output_pin_oe |-> result_output_pin == $past(edges.result))
      else $error("Driven pin does not carry the result");
   a_pin_off_undriven: assert property (@(posedge clock) disable iff (srst)
      !result_output_pin_oe |-> !result_output_pin)
      else $error("Undriven pin carries a value");
   a_status_shows_result: assert property (@(posedge clock) disable iff (srst)
      control_word[8] == (u_result_edge_detector.sync_second ^ invert))
      else $error("Result status bit not the inverted result");
   a_no_event_none: assert property (@(posedge clock) disable iff (srst)
      edge_select == 2'h0 |=> !event_pulse)
      else $error("Event pulse while edge selection is none");
   a_rising_gives_pulse: assert property (@(posedge clock) disable iff (srst)
      edge_select == 2'h1 && edges.rise |=> event_pulse ##1 !event_pulse)
      else $error("Rising edge did not give a single pulse");
   a_rising_only: assert property (@(posedge clock) disable iff (srst)
      edge_select == comparator_pkg::EDGE_RISING && !edges.rise |=> !event_pulse)
      else $error("Pulse without a rising edge in rising mode");
   a_falling_only: assert property (@(posedge clock) disable iff (srst)
      edge_select == 2'h2 && !edges.fall |=> !event_pulse)
      else $error("Pulse without a falling edge in falling mode");
   a_falling_gives_pulse: assert property (@(posedge clock) disable iff (srst)
      edge_select == comparator_pkg::EDGE_FALLING && edges.fall |=> event_pulse ##1 !event_pulse)
      else $error("Falling edge did not give a single pulse");
   a_both_gives_pulse: assert property (@(posedge clock) disable iff (srst)
      edge_select == comparator_pkg::EDGE_BOTH && (edges.rise || edges.fall) |=> event_pulse)
      else $error("Edge lost in both-edges mode");
   a_no_event_disabled: assert property (@(posedge clock) disable iff (srst)
      !enable |=> !event_pulse)
      else $error("Event pulse while comparator disabled");
   a_disabled_no_edges: assert property (@(posedge clock) disable iff (srst)
      !enable |-> !edges.rise && !edges.fall)
      else $error("Edge detected while comparator disabled");
   // Switch-on itself must never look like a result edge
   a_no_edge_first: assert property (@(posedge clock) disable iff (srst)
      $rose(enable) |-> !edges.rise && !edges.fall)
      else $error("Edge detected on the switch-on cycle");
   a_reserved_read_zero: assert property (@(posedge clock) disable iff (srst)
      (control_word & ~32'h0000E1D3) == 32'h00000000)
      else $error("Unimplemented control bits not zero");
   a_select_outputs: assert property (@(posedge clock) disable iff (srst)
      write_control && byteenable[0] |=>
         negative_input_select == $past(writedata[1:0])
         && positive_input_select == $past(writedata[4]))
      else $error("Input selection did not take written value");

   // ----------------------------------------
   // Bus and interrupt checks
   // ----------------------------------------
   a_read_answer: assert property (@(posedge clock) disable iff (srst)
      read && !read_done |=> !waitrequest || !read)
      else $error("Read not answered after one wait cycle");
   a_write_no_wait: assert property (@(posedge clock) disable iff (srst)
      write |-> !waitrequest)
      else $error("Write stalled by waitrequest");
   a_control_read_back: assert property (@(posedge clock) disable iff (srst)
      read && !read_done && address == comparator_pkg::CONTROL_OFFSET |=>
         readdata == $past(control_word))
      else $error("Control read data not the control word");
   a_unmapped_read_zero: assert property (@(posedge clock) disable iff (srst)
      read && !read_done && address != comparator_pkg::CONTROL_OFFSET
         && address != comparator_pkg::STATUS_OFFSET
         && address != comparator_pkg::MASK_OFFSET |=> readdata == 32'h00000000)
      else $error("Unmapped address read not zero");
   a_readdata_holds: assert property (@(posedge clock) disable iff (srst)
      !(read && !read_done) |=> readdata == $past(readdata))
      else $error("Read data changed outside a read capture");
   a_status_set_wins: assert property (@(posedge clock) disable iff (srst)
      next_event |=> event_status)
      else $error("Event lost in status register");
   // Sticky so software cannot miss an event between polls
   a_status_sticky: assert property (@(posedge clock) disable iff (srst)
      event_status && !write_status |=> event_status)
      else $error("Status cleared without a write");
   a_status_clears: assert property (@(posedge clock) disable iff (srst)
      write_status && byteenable[0] && writedata[comparator_pkg::EVENT_BIT] && !next_event
         |=> !event_status)
      else $error("Write-one did not clear the status");
   a_mask_takes_bit: assert property (@(posedge clock) disable iff (srst)
      write_mask && byteenable[0] |=> event_mask == $past(writedata[comparator_pkg::EVENT_BIT]))
      else $error("Mask did not take written value");
endmodule

//--- dv/comparator_core_model.sv
// Behavioural model of the analog comparator core and its input pins
`timescale 1ns/10ps
module comparator_core_model (
   input  wire logic            positive_input_select,
   input  wire logic [1:0]      negative_input_select,
   input  wire logic [5:0][7:0] level,
   output logic                 comparator_result
);
   // ----------------------------------------
   // Input routing and comparison
   // ----------------------------------------
   // Levels: 0 pin A, 1 to 3 pins B to D, 4 positive ref, 5 negative ref
   // Output follows inputs even when off, so only the logic can mask it
   logic [7:0] positive_level;
   logic [7:0] negative_level;
   assign positive_level = positive_input_select ? level[4] : level[0];
   always_comb begin
      case (negative_input_select)
         2'h0: negative_level = level[1];
         2'h1: negative_level = level[2];
         2'h2: negative_level = level[3];
         default: negative_level = level[5];
      endcase
   end
   assign comparator_result = positive_level > negative_level;
endmodule

//--- dv/comparator_control_event_tb.sv
// Self-checking bench for the comparator control and edge interrupt block
`timescale 1ns/10ps
`define CHECK(what, exp, got) \
   begin \
      tests_run = tests_run + 1; \
      if ((got) !== (exp)) begin \
         failures = failures + 1; \
         $display("ERROR %s expected %h seen %h", what, exp, got); \
      end \
   end
module comparator_control_event_tb;
   logic            clock = 1'b0;
   logic            srst = 1'b1;
   logic [3:0]      address = 4'h0;
   logic            read = 1'b0;
   logic            write = 1'b0;
   logic [31:0]     writedata = 32'h0;
   logic [3:0]      byteenable = 4'h0;
   logic [5:0][7:0] level = '0;
   logic [31:0]     readdata;
   logic            waitrequest;
   logic            comparator_result;
   logic            comparator_enable;
   logic            positive_input_select;
   logic [1:0]      negative_input_select;
   logic            result_output_pin;
   logic            result_output_pin_oe;
   logic            event_pulse;
   logic            interrupt;
   logic [31:0]     rd;
   int              failures = 0;
   int              tests_run = 0;
   int              pulses;
   // ----------------------------------------
   // Instances and clock
   // ----------------------------------------
   comparator_control_event u_comparator_control_event (.clock(clock), .srst(srst),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
      .comparator_result(comparator_result), .comparator_enable(comparator_enable),
      .positive_input_select(positive_input_select),
      .negative_input_select(negative_input_select), .result_output_pin(result_output_pin),
      .result_output_pin_oe(result_output_pin_oe), .event_pulse(event_pulse),
      .interrupt(interrupt));
   comparator_core_model u_comparator_core_model (.positive_input_select(positive_input_select),
      .negative_input_select(negative_input_select), .level(level),
      .comparator_result(comparator_result));
   initial begin
      forever #5 clock = ~clock;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Request held until waitrequest sampled low at a rising edge; bound stops a hung slave
   task automatic bus(input logic rnw, input logic [3:0] addr, input logic [31:0] data,
                      input logic [3:0] be);
      int n = 0;
      @(posedge clock);
      read <= rnw;
      write <= !rnw;
      address <= addr;
      writedata <= data;
      byteenable <= be;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) begin
         failures++;
         end_sim();
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // Outputs launched at the answer edge are looked at once settled
      @(negedge clock);
   endtask
   // Two sync flops plus pipeline: settle before looking
   task automatic set_level(input logic [5:0][7:0] v);
      @(posedge clock);
      level <= v;
      pulses = 0;
      repeat (8) begin
         @(negedge clock);
         if (event_pulse !== 1'b0) pulses++;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      bus(1'b1, 4'h0, 32'h0, 4'hF);
      `CHECK("control reset", comparator_pkg::CONTROL_RESET, rd)
      bus(1'b0, 4'hC, 32'hFFFFFFFF, 4'hF);
      bus(1'b1, 4'hC, 32'h0, 4'hF);
      `CHECK("unmapped", 32'h0, rd)
      `CHECK("reset irq", 1'b0, interrupt)
      $display("test reset done");
   endtask
   task automatic t_fields();
      bus(1'b0, 4'h0, 32'hFFFFFFFF, 4'hF);
      bus(1'b1, 4'h0, 32'h0, 4'hF);
      `CHECK("all ones", 32'h0000E1D3, rd)
      bus(1'b0, 4'h0, 32'h00000100, 4'hF);
      bus(1'b1, 4'h0, 32'h0, 4'hF);
      `CHECK("result write", 32'h0, rd)
      bus(1'b0, 4'h0, 32'h0000C0D1, 4'hF);
      `CHECK("enable on", 1'b1, comparator_enable)
      bus(1'b0, 4'h0, 32'h0, 4'h2);
      bus(1'b1, 4'h0, 32'h0, 4'hF);
      `CHECK("enable off", 32'h000000D1, rd)
      `CHECK("enable pin", 1'b0, comparator_enable)
      bus(1'b0, 4'h4, 32'h1, 4'hF);
      $display("test fields done");
   endtask
   task automatic t_select();
      for (int k = 0; k < 4; k++) begin
         bus(1'b0, 4'h0, {30'h0, k[1:0]}, 4'hF);
         set_level({k == 3 ? 8'h00 : 8'hC8, 8'h00, k == 2 ? 8'h00 : 8'hC8,
                    k == 1 ? 8'h00 : 8'hC8, k == 0 ? 8'h00 : 8'hC8, 8'h64});
         bus(1'b1, 4'h0, 32'h0, 4'hF);
         `CHECK("negative route", 1'b1, rd[8])
         `CHECK("negative port", k[1:0], negative_input_select)
      end
      for (int p = 0; p < 2; p++) begin
         bus(1'b0, 4'h0, {27'h0, p[0], 4'h3}, 4'hF);
         set_level(48'hC8_FA_C8_C8_C8_64);
         bus(1'b1, 4'h0, 32'h0, 4'hF);
         `CHECK("positive route", p[0], rd[8])
         `CHECK("positive port", p[0], positive_input_select)
      end
      $display("test select done");
   endtask
   task automatic t_pin();
      set_level(48'hC8_FA_00_00_00_00);
      for (int m = 0; m < 4; m++) begin
         bus(1'b0, 4'h0, {16'h0, 1'b0, m[1], m[0], 13'h13}, 4'hF);
         set_level(48'hC8_FA_00_00_00_00);
         bus(1'b1, 4'h0, 32'h0, 4'hF);
         `CHECK("status bit", !m[0], rd[8])
         `CHECK("pin value", m[1] & !m[0], result_output_pin)
         `CHECK("pin enable", m[1], result_output_pin_oe)
      end
      $display("test pin done");
   endtask
   task automatic t_edges();
      bus(1'b0, 4'h8, 32'h1, 4'hF);
      for (int m = 0; m < 8; m++) begin
         set_level(48'h64_00_00_00_00_00);
         bus(1'b0, 4'h0, {18'h0, m[0], 5'h0, m[2:1], 6'h13}, 4'hF);
         bus(1'b0, 4'h0, {16'h0, 1'b1, 1'b0, m[0], 5'h0, m[2:1], 6'h13}, 4'hF);
         repeat (4) @(posedge clock);
         bus(1'b0, 4'h4, 32'h1, 4'hF);
         set_level(48'h64_C8_00_00_00_00);
         `CHECK("rise count", int'(m[0] ? m[2] : m[1]), pulses)
         `CHECK("rise irq", m[0] ? m[2] : m[1], interrupt)
         bus(1'b0, 4'h4, 32'h1, 4'hF);
         set_level(48'h64_00_00_00_00_00);
         `CHECK("fall count", int'(m[0] ? m[1] : m[2]), pulses)
         bus(1'b0, 4'h4, 32'h1, 4'hF);
         `CHECK("cleared irq", 1'b0, interrupt)
      end
      bus(1'b0, 4'h8, 32'h0, 4'hF);
      set_level(48'h64_C8_00_00_00_00);
      bus(1'b1, 4'h4, 32'h0, 4'hF);
      `CHECK("masked status", 32'h1, rd)
      `CHECK("masked irq", 1'b0, interrupt)
      bus(1'b0, 4'h0, 32'h0, 4'h2);
      bus(1'b0, 4'h4, 32'h1, 4'hF);
      set_level(48'h64_00_00_00_00_00);
      `CHECK("disabled", 0, pulses)
      $display("test edges done");
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      t_reset();
      t_fields();
      t_select();
      t_pin();
      t_edges();
      end_sim();
   end
endmodule
